// ### hdl/bcrc_top.sv
/*
  Byte-serial CRC-16 unit: input byte register, running result register,
  a status register and a byte counter behind a simple strobe port.
  Assumes one clock, synchronous active-low reset, and a master that never
  raises both strobes at once and samples read data the cycle after.
*/
// What this block does
// (R01) 16-bit CRC over any number of bytes, generator x^16+x^12+x^5+1.
// (R02) each byte write updates the result from its current value.
// (R03) input register is 8 bits, byte access, resets to zero.
// (R04) result register is 16 bits, halfword access only, resets to zero.
// (R05) software must not touch the result register on slow or internal clock.
// (R06) bytes are folded lsb first; result is remainder of message times x^16.
// (R07) software loads zero into the result before the first byte.
// (R08) sender sends the result low byte first, then high byte.
// (R09) payload then received CRC bytes fed in leaves the result at zero.
// (R10) receiver treats a nonzero result as an error and requests a resend.
// (R11) the update finishes within one clock, before the next access.
`default_nettype none

module bcrc_top (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic [3:0]  bus_addr,
  input  wire logic [15:0] bus_wdata,
  input  wire logic [1:0]  bus_lanes,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  input  wire logic        cpu_slow_clock,
  output logic      [15:0] bus_rdata,
  output logic      [7:0]  crc_byte_input,
  output logic      [15:0] crc_running_result,
  output logic             crc_is_zero
);

  bcrc_pkg::bcrc_sel_t sel;
  logic        lanes_byte;
  logic        lanes_half;
  logic        width_ok;
  logic        result_blocked;
  logic        wr_input;
  logic        wr_result;
  logic        wr_status;
  logic        rd_result;
  logic        bad_width;
  logic        bad_clock;
  logic [15:0] crc_next;
  logic [15:0] result_din;
  logic        result_load;
  logic [15:0] count_q;
  logic [15:0] count_din;
  logic        count_load;
  logic        width_err_d;
  logic        width_err_q;
  logic        clock_err_d;
  logic        clock_err_q;
  logic [15:0] rdata_d;
  logic [15:0] rdata_q;
  logic [15:0] status_word;

  // address decode
  always_comb begin
    unique case (bus_addr)
      bcrc_pkg::OFS_INPUT:  sel = bcrc_pkg::SEL_INPUT;
      bcrc_pkg::OFS_RESULT: sel = bcrc_pkg::SEL_RESULT;
      bcrc_pkg::OFS_STATUS: sel = bcrc_pkg::SEL_STATUS;
      bcrc_pkg::OFS_COUNT:  sel = bcrc_pkg::SEL_COUNT;
      default:              sel = bcrc_pkg::SEL_NONE;
    endcase
  end

  // access width check: byte on the input, halfword on the result
  assign lanes_byte = (bus_lanes == bcrc_pkg::LANES_BYTE);
  assign lanes_half = (bus_lanes == bcrc_pkg::LANES_HALF);

  always_comb begin
    unique case (sel)
      bcrc_pkg::SEL_INPUT:  width_ok = lanes_byte; // R03
      bcrc_pkg::SEL_RESULT: width_ok = lanes_half; // R04
      bcrc_pkg::SEL_STATUS: width_ok = lanes_half;
      bcrc_pkg::SEL_COUNT:  width_ok = lanes_half;
      default:              width_ok = 1'b1;
    endcase
  end

  // result access is refused while the cpu runs from a slow clock
  assign result_blocked = cpu_slow_clock && (sel == bcrc_pkg::SEL_RESULT); // R05

  // qualified write and read strobes
  assign wr_input  = bus_wr && (sel == bcrc_pkg::SEL_INPUT) && width_ok;
  assign wr_result = bus_wr && (sel == bcrc_pkg::SEL_RESULT) && width_ok
                     && !result_blocked;
  assign wr_status = bus_wr && (sel == bcrc_pkg::SEL_STATUS) && width_ok;
  assign rd_result = bus_rd && (sel == bcrc_pkg::SEL_RESULT) && width_ok
                     && !result_blocked;

  // error events for the sticky status bits
  assign bad_width = (bus_wr || bus_rd) && !width_ok;
  assign bad_clock = (bus_wr || bus_rd) && result_blocked;

  // input byte register
  bcrc_field_reg #(
    .W   (8),
    .RST (bcrc_pkg::INPUT_RST)
  ) u_input (
    .clock (clock),
    .rst_b (rst_b),
    .load  (wr_input),                  // R03
    .din   (bus_wdata[7:0]),
    .q     (crc_byte_input)
  );

  // fold the written byte into the current result, lsb first
  bcrc_byte_step u_step (
    .crc_in  (crc_running_result),      // R02
    .data_in (bus_wdata[7:0]),          // R06
    .crc_out (crc_next)                 // R01
  );

  // result source: software preset, or the byte update in the same cycle
  always_comb begin
    result_load = wr_result || wr_input;
    if (wr_result) begin
      result_din = bus_wdata;           // R07
    end else begin
      result_din = crc_next;            // R11
    end
  end

  // running result register
  bcrc_field_reg #(
    .W   (16),
    .RST (bcrc_pkg::RESULT_RST)
  ) u_result (
    .clock (clock),
    .rst_b (rst_b),
    .load  (result_load),               // R04
    .din   (result_din),
    .q     (crc_running_result)
  );

  // zero result marks a good reception after the crc bytes are fed
  assign crc_is_zero = (crc_running_result == bcrc_pkg::CRC_GOOD); // R09

  // bytes fed since the result was last preset
  always_comb begin
    count_load = wr_result || wr_input;
    if (wr_result) begin
      count_din = bcrc_pkg::COUNT_RST;
    end else begin
      count_din = count_q + 16'h0001;   // wraps
    end
  end

  bcrc_field_reg #(
    .W   (16),
    .RST (bcrc_pkg::COUNT_RST)
  ) u_count (
    .clock (clock),
    .rst_b (rst_b),
    .load  (count_load),
    .din   (count_din),
    .q     (count_q)
  );

  // sticky error flags, write one to clear, a new event wins over the clear
  always_comb begin
    width_err_d = width_err_q;
    clock_err_d = clock_err_q;
    if (wr_status && bus_wdata[bcrc_pkg::STAT_WIDTH_ERR]) begin
      width_err_d = 1'b0;
    end
    if (wr_status && bus_wdata[bcrc_pkg::STAT_CLOCK_ERR]) begin
      clock_err_d = 1'b0;
    end
    if (bad_width) begin
      width_err_d = 1'b1;
    end
    if (bad_clock) begin
      clock_err_d = 1'b1;               // R05
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      width_err_q <= bcrc_pkg::FLAG_RST;
      clock_err_q <= bcrc_pkg::FLAG_RST;
    end else begin
      width_err_q <= width_err_d;
      clock_err_q <= clock_err_d;
    end
  end

  // status word layout
  always_comb begin
    status_word = 16'h0000;
    status_word[bcrc_pkg::STAT_WIDTH_ERR] = width_err_q;
    status_word[bcrc_pkg::STAT_CLOCK_ERR] = clock_err_q;
    status_word[bcrc_pkg::STAT_ZERO]      = crc_is_zero;
  end

  // read data, valid only in the cycle after the read strobe
  always_comb begin
    rdata_d = 16'h0000;
    if (bus_rd && width_ok) begin
      unique case (sel)
        bcrc_pkg::SEL_INPUT:  rdata_d = {8'h00, crc_byte_input};
        bcrc_pkg::SEL_RESULT: rdata_d = rd_result ? crc_running_result : 16'h0000;
        bcrc_pkg::SEL_STATUS: rdata_d = status_word;
        bcrc_pkg::SEL_COUNT:  rdata_d = count_q;
        default:              rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign bus_rdata = rdata_q;

endmodule

`default_nettype wire

// ### hdl/bcrc_pkg.sv
/*
  Shared constants for the byte-serial CRC-16 unit: register offsets,
  field positions, reset values, access widths and the feedback polynomial.
  Assumes a 16-bit register port with byte-lane enables on a single clock.
*/
`default_nettype none

package bcrc_pkg;

  // register port geometry
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned BYTE_W = 8;

  // register offsets (byte addresses on the port)
  localparam logic [3:0] OFS_INPUT  = 4'h0;
  localparam logic [3:0] OFS_RESULT = 4'h2;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_COUNT  = 4'h6;

  // reset values
  localparam logic [7:0]  INPUT_RST  = 8'h00;
  localparam logic [15:0] RESULT_RST = 16'h0000;
  localparam logic [15:0] COUNT_RST  = 16'h0000;
  localparam logic        FLAG_RST   = 1'b0;

  // byte-lane patterns for a byte access and a halfword access
  localparam logic [1:0] LANES_BYTE = 2'b01;
  localparam logic [1:0] LANES_HALF = 2'b11;

  // status register field positions
  localparam int unsigned STAT_WIDTH_ERR = 0;
  localparam int unsigned STAT_CLOCK_ERR = 1;
  localparam int unsigned STAT_ZERO      = 2;

  // x^16 + x^12 + x^5 + 1, bit-reversed for lsb-first shifting
  localparam logic [15:0] POLY_LSB_FIRST = 16'h8408;
  localparam logic [15:0] CRC_GOOD       = 16'h0000;

  // address decode result
  typedef enum logic [2:0] {
    SEL_NONE   = 3'b000,
    SEL_INPUT  = 3'b001,
    SEL_RESULT = 3'b010,
    SEL_STATUS = 3'b011,
    SEL_COUNT  = 3'b100
  } bcrc_sel_t;

endpackage

`default_nettype wire

// ### hdl/bcrc_byte_step.sv
/*
  One-byte CRC-16 step: folds eight data bits into the running remainder,
  least significant bit first. Purely combinational.
  Assumes the caller registers the result.
*/
`default_nettype none

module bcrc_byte_step (
  input  wire logic [15:0] crc_in,
  input  wire logic [7:0]  data_in,
  output logic      [15:0] crc_out
);

  // shift each bit in, lsb first, dividing by the generator
  always_comb begin
    logic [15:0] c;
    logic        fb;
    c  = crc_in;
    fb = 1'b0;
    for (int i = 0; i < 8; i++) begin
      fb = c[0] ^ data_in[i];
      c  = {1'b0, c[15:1]};
      if (fb) begin
        c = c ^ bcrc_pkg::POLY_LSB_FIRST;
      end
    end
    crc_out = c;
  end

endmodule

`default_nettype wire

// ### hdl/bcrc_field_reg.sv
/*
  Loadable storage register with a fixed reset value.
  Assumes a synchronous active-low reset on the shared clock.
*/
`default_nettype none

module bcrc_field_reg #(
  parameter int unsigned      W   = 8,
  parameter logic [W-1:0]     RST = '0
) (
  input  wire logic         clock,
  input  wire logic         rst_b,
  input  wire logic         load,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] q
);

  logic [W-1:0] val_d;
  logic [W-1:0] val_q;

  // hold unless loaded
  always_comb begin
    val_d = load ? din : val_q;
  end

  // storage with synchronous reset
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      val_q <= RST;
    end else begin
      val_q <= val_d;
    end
  end

  assign q = val_q;

endmodule

`default_nettype wire

// ### dv/bcrc_monitor.sv
/*
  Port checker for the byte-serial crc unit.
  Assumes it is bound to bcrc_top, one clock, synchronous active-low reset.
*/
`default_nettype none

module bcrc_monitor (
  input wire logic        clock,
  input wire logic        rst_b,
  input wire logic [3:0]  bus_addr,
  input wire logic [15:0] bus_wdata,
  input wire logic [1:0]  bus_lanes,
  input wire logic        bus_wr,
  input wire logic        bus_rd,
  input wire logic        cpu_slow_clock,
  input wire logic [15:0] bus_rdata,
  input wire logic [7:0]  crc_byte_input,
  input wire logic [15:0] crc_running_result,
  input wire logic        crc_is_zero
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);

  // legal byte write to input, legal halfword write to result
  wire logic in_wr = bus_wr && bus_addr == 4'h0 && bus_lanes == 2'h1;
  wire logic res_wr = bus_wr && bus_addr == 4'h2 && bus_lanes == 2'h3 && !cpu_slow_clock;

  // load of zero, then byte 01
  sequence s_load_zero;
    res_wr && bus_wdata == 16'h0000;
  endsequence
  sequence s_byte_one;
    in_wr && bus_wdata[7:0] == 8'h01;
  endsequence

  property p_walk;
    s_load_zero ##1 s_byte_one |=> crc_running_result == 16'h1189;
  endproperty
  a_walk: assert property (p_walk) else $error("byte fold wrong");
  property p_idle;
    !$past(bus_rd) |-> bus_rdata == 16'h0000;
  endproperty
  a_idle: assert property (p_idle) else $error("read data outside slot");
  property p_zero;
    crc_is_zero == (crc_running_result == 16'h0000);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");
  property p_in_wr;
    in_wr |=> crc_byte_input == $past(bus_wdata[7:0]);
  endproperty
  a_in_wr: assert property (p_in_wr) else $error("input not loaded");
  property p_res_wr;
    res_wr |=> crc_running_result == $past(bus_wdata);
  endproperty
  a_res_wr: assert property (p_res_wr) else $error("result not loaded");
  property p_hold;
    !in_wr && !res_wr |=> $stable(crc_running_result);
  endproperty
  a_hold: assert property (p_hold) else $error("result moved");
  property p_hold_in;
    !in_wr |=> $stable(crc_byte_input);
  endproperty
  a_hold_in: assert property (p_hold_in) else $error("input moved");
  property p_rd_in;
    bus_rd && bus_addr == 4'h0 && bus_lanes == 2'h1
      |=> bus_rdata == {8'h00, $past(crc_byte_input)};
  endproperty
  a_rd_in: assert property (p_rd_in) else $error("input read wrong");
  property p_rd_res;
    bus_rd && bus_addr == 4'h2 && bus_lanes == 2'h3 && !cpu_slow_clock
      |=> bus_rdata == $past(crc_running_result);
  endproperty
  a_rd_res: assert property (p_rd_res) else $error("result read wrong");
endmodule

`default_nettype wire

// ### dv/bcrc_tb_top.sv
/*
  Self-checking bench for the byte-serial crc unit with a reference model.
  Assumes bcrc_top and the port checker are compiled before it.
*/
`default_nettype none

module bcrc_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 0, rst_b = 0, bus_wr = 0, bus_rd = 0, cpu_slow_clock = 0;
  logic [3:0]  bus_addr = 4'h0;
  logic [1:0]  bus_lanes = 2'h0;
  logic [15:0] bus_wdata = 16'h0, bus_rdata, crc_running_result, res, e, d, p;
  logic [7:0]  crc_byte_input, f;
  logic [7:0]  msg_q[$];
  logic        crc_is_zero;
  int          error_cnt = 0, checks = 0, cyc = 0, seed = 32'h2b2fc064;

  // 40 mhz clock
  always #12.5 clock = ~clock;

  bcrc_top dut_u (.clock(clock), .rst_b(rst_b), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_lanes(bus_lanes), .bus_wr(bus_wr), .bus_rd(bus_rd), .cpu_slow_clock(cpu_slow_clock),
    .bus_rdata(bus_rdata), .crc_byte_input(crc_byte_input),
    .crc_running_result(crc_running_result), .crc_is_zero(crc_is_zero));

  task chk(input logic [15:0] s, input logic [15:0] x, input string n);
    checks++;
    if (s !== x) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", n, x, s);
    end
  endtask

  // one bus cycle; strobes stay as given until the next call
  task op(input logic w, input logic r, input logic [3:0] a, input logic [15:0] v,
          input logic [1:0] l);
    bus_wr <= w;
    bus_rd <= r;
    bus_addr <= a;
    bus_wdata <= v;
    bus_lanes <= l;
    @(posedge clock);
    #1;
  endtask

  task rd(input logic [3:0] a, input logic [1:0] l, input logic [15:0] x, input string n);
    op(1'b0, 1'b1, a, 16'h0, l);
    chk(bus_rdata, x, n);
  endtask

  // reference fold, lsb first, reflected x^16+x^12+x^5+1
  function logic [15:0] step(input logic [15:0] c, input logic [7:0] b);
    for (int i = 0; i < 8; i++) c = (c >> 1) ^ ((c[0] ^ b[i]) ? 16'h8408 : 16'h0);
    return c;
  endfunction

  task end_of_test;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // hang guard
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      end_of_test;
    end
  end

  initial begin
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    rd(4'h0, 2'h1, 16'h0, "input reset");
    rd(4'h2, 2'h3, 16'h0, "result reset");
    chk(crc_is_zero, 16'h1, "zero flag");
    op(1'b1, 1'b0, 4'h2, 16'h0, 2'h3);
    op(1'b1, 1'b0, 4'h0, 16'h0001, 2'h1);
    rd(4'h2, 2'h3, 16'h1189, "byte 01");
    $display("reset and single byte done");
    // random messages, then the crc appended low byte first; message 1 has a bit error
    for (int m = 0; m < 4; m++) begin
      res = (m == 0) ? 16'h0 : 16'($random(seed));
      p = res;
      msg_q.delete();
      op(1'b1, 1'b0, 4'h2, res, 2'h3);
      for (int k = 0; k < 2 + 3 * m; k++) begin
        d = 16'($random(seed));
        op(1'b1, 1'b0, 4'h0, d, 2'h1);
        msg_q.push_back(d[7:0]);
        res = step(res, d[7:0]);
        chk(crc_running_result, res, "running");
      end
      // whole-message fold from the preset, kept apart from the running model
      foreach (msg_q[i]) p = step(p, msg_q[i]);
      rd(4'h0, 2'h1, {8'h0, d[7:0]}, "input back");
      rd(4'h2, 2'h3, p, "message crc");
      e = res;
      f = e[7:0] ^ {7'h0, m == 1};
      op(1'b1, 1'b0, 4'h0, {8'h0, f}, 2'h1);
      op(1'b1, 1'b0, 4'h0, {8'h0, e[15:8]}, 2'h1);
      res = step(step(res, f), e[15:8]);
      chk(crc_running_result, res, "residue");
      chk(crc_is_zero, {15'h0, m != 1}, "residue flag");
      rd(4'h6, 2'h3, 16'(4 + 3 * m), "byte count");
    end
    $display("message test done");
    // refused accesses leave registers alone
    op(1'b1, 1'b0, 4'h2, 16'hffff, 2'h1);
    op(1'b1, 1'b0, 4'h0, 16'h00aa, 2'h3);
    rd(4'h2, 2'h1, 16'h0, "narrow read");
    cpu_slow_clock <= 1'b1;
    op(1'b1, 1'b0, 4'h2, 16'h1234, 2'h3);
    rd(4'h2, 2'h3, 16'h0, "slow read");
    cpu_slow_clock <= 1'b0;
    rd(4'h8, 2'h3, 16'h0, "unmapped");
    chk(crc_running_result, res, "result kept");
    chk(crc_byte_input, {8'h0, e[15:8]}, "input kept");
    // sticky width and slow-clock flags, live zero bit, then write one to clear
    rd(4'h4, 2'h3, 16'h0007, "status flags");
    op(1'b1, 1'b0, 4'h4, 16'h0003, 2'h3);
    rd(4'h4, 2'h3, 16'h0004, "status cleared");
    $display("refusal test done");
    // second reset in mid-run, over a nonzero result
    op(1'b1, 1'b0, 4'h2, 16'h5a5a, 2'h3);
    chk(crc_running_result, 16'h5a5a, "preset");
    rst_b <= 1'b0;
    op(1'b0, 1'b0, 4'h0, 16'h0, 2'h0);
    rst_b <= 1'b1;
    chk(crc_running_result, 16'h0, "result rerst");
    chk(crc_byte_input, 16'h0, "input rerst");
    op(1'b1, 1'b0, 4'h0, 16'h0001, 2'h1);
    chk(crc_running_result, 16'h1189, "byte after reset");
    rd(4'h6, 2'h3, 16'h0001, "count after reset");
    $display("reset again done");
    end_of_test;
  end
endmodule

bind bcrc_top bcrc_monitor mon_u (.clock(clock), .rst_b(rst_b), .bus_addr(bus_addr),
  .bus_wdata(bus_wdata), .bus_lanes(bus_lanes), .bus_wr(bus_wr), .bus_rd(bus_rd),
  .cpu_slow_clock(cpu_slow_clock), .bus_rdata(bus_rdata), .crc_byte_input(crc_byte_input),
  .crc_running_result(crc_running_result), .crc_is_zero(crc_is_zero));

`default_nettype wire
